//--- core/icc_core.v
// How it works
// - control bit 7 picks which of two timers gets captured.
// - two-bit field sets captures per interrupt: one to four events.
// - read-only overflow flag sets when a capture finds the buffer full.
// - mode 111: rising edge raises interrupt only, other bits ignored.
// - mode 110 is unused: no captures or interrupts, and overflow is not cleared.
// - mode 101 captures every 16th rising edge, 100 every 4th.
// - mode 011 captures every rising edge, 010 every falling edge.
// - mode 001 captures both edges; interrupt on every capture.
`timescale 1ns/1ps
`include "icc_map.vh"

module icc_core #(
  parameter TW = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // capture input pin
  input wire cap_pin,
  // timer count values
  input wire [TW-1:0] timer_a,
  input wire [TW-1:0] timer_b,
  // interrupt
  output wire irq
);

  // ****************************************
  // declarations
  // ****************************************
  reg tmr_sel_r;
  reg [1:0] ici_r;
  reg [2:0] mode_r;
  reg ov_r;
  reg [`ICC_ST_W-1:0] stat_r;
  reg [`ICC_ST_W-1:0] mask_r;
  reg pin_s1_r;
  reg pin_s2_r;
  reg pin_d_r;
  reg [3:0] pre_cnt_r;
  reg [1:0] ici_cnt_r;
  reg [TW-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] cnt_r;
  reg pop_pend_r;
  reg [31:0] rd_mux;
  wire setup;
  wire access;
  wire wr_en;
  wire wr_en_ctrl;
  wire ici_hit;
  wire addr_ok;
  wire rise;
  wire fall;
  wire mode_off;
  wire pre_mode;
  wire [3:0] pre_last;
  wire pre_hit;
  reg cap_evt;
  wire int_evt;
  wire full;
  wire empty;
  wire push;
  wire pop;
  wire ov_evt;
  wire [TW-1:0] cap_val;
  wire [7:0] ctrl_rd;

  // ****************************************
  // apb decode
  // ****************************************

  // slave never stalls, so pready stays high
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_en = access & pwrite;
  assign addr_ok = (paddr == `ICC_OFF_CTRL) |
                   (paddr == `ICC_OFF_BUF) |
                   (paddr == `ICC_OFF_STAT) |
                   (paddr == `ICC_OFF_MASK);
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;

  // ****************************************
  // pin synchroniser and edge detect
  // ****************************************

  // second and third stages feed the edge detector, never the first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s1_r <= cap_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign rise = pin_s2_r & ~pin_d_r;
  assign fall = ~pin_s2_r & pin_d_r;

  // ****************************************
  // mode decode and prescaler
  // ****************************************

  // unused code counts as off for the interrupt counter
  assign mode_off = (mode_r == `ICC_M_OFF) |
                    (mode_r == `ICC_M_UNUSED);
  assign pre_mode = (mode_r == `ICC_M_DIV4) |
                    (mode_r == `ICC_M_DIV16);
  assign pre_last = (mode_r == `ICC_M_DIV16) ? `ICC_DIV16_LAST :
                    `ICC_DIV4_LAST;
  assign pre_hit = pre_mode & rise & (pre_cnt_r == pre_last);

  // rising edge counter for the divided modes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 4'h0;
    end else if (!pre_mode || wr_en_ctrl) begin
      pre_cnt_r <= 4'h0;
    end else if (rise) begin
      if (pre_hit) begin
        pre_cnt_r <= 4'h0;
      end else begin
        pre_cnt_r <= pre_cnt_r + 4'h1;
      end
    end
  end

  // capture strobe per mode
  always @* begin
    cap_evt = 1'b0;
    case (mode_r)
      `ICC_M_BOTH: cap_evt = rise | fall;
      `ICC_M_FALL: cap_evt = fall;
      `ICC_M_RISE: cap_evt = rise;
      `ICC_M_DIV4: cap_evt = pre_hit;
      `ICC_M_DIV16: cap_evt = pre_hit;
      default: cap_evt = 1'b0;
    endcase
  end

  // ****************************************
  // captures per interrupt
  // ****************************************
  // declared up top: the prescaler clear above reads it too

  assign wr_en_ctrl = wr_en & (paddr == `ICC_OFF_CTRL);
  // field value n means interrupt on every (n+1)th capture
  assign ici_hit = (ici_cnt_r == ici_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ici_cnt_r <= 2'b00;
    end else if (mode_off || wr_en_ctrl) begin
      ici_cnt_r <= 2'b00;
    end else if (cap_evt && mode_r != `ICC_M_BOTH) begin
      if (ici_hit) begin
        ici_cnt_r <= 2'b00;
      end else begin
        ici_cnt_r <= ici_cnt_r + 2'b01;
      end
    end
  end

  // both-edge mode ignores the field; int-only uses raw rise
  assign int_evt = (mode_r == `ICC_M_INTONLY) ? rise :
                   (mode_r == `ICC_M_BOTH) ? cap_evt :
                   (cap_evt & ici_hit);

  // ****************************************
  // capture buffer
  // ****************************************
  assign cap_val = tmr_sel_r ? timer_b : timer_a;
  assign full = (cnt_r == DEPTH[AW:0]);
  assign empty = (cnt_r == {(AW+1){1'b0}});
  // a capture into a full buffer is dropped, not overwritten
  assign push = cap_evt & ~full;
  assign ov_evt = cap_evt & full;
  assign pop = pop_pend_r & access;

  always @(posedge pclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= cap_val;
    end
  end

  // pointers and fill level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // control register
  // ****************************************

  // overflow clears in hardware only, when the channel is switched off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_sel_r <= 1'b0;
      ici_r <= 2'b00;
      mode_r <= `ICC_M_OFF;
      ov_r <= 1'b0;
    end else begin
      if (wr_en_ctrl) begin
        tmr_sel_r <= pwdata[`ICC_TMR_BIT];
        ici_r <= pwdata[`ICC_ICI_HI:`ICC_ICI_LO];
        mode_r <= pwdata[`ICC_MODE_HI:`ICC_MODE_LO];
      end
      if (ov_evt) begin
        ov_r <= 1'b1;
      end else if (mode_r == `ICC_M_OFF) begin
        ov_r <= 1'b0;
      end
    end
  end

  assign ctrl_rd = {tmr_sel_r, ici_r, ov_r, ~empty, mode_r};

  // ****************************************
  // interrupt status and mask
  // ****************************************

  // a new event beats a write-one-to-clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= {`ICC_ST_W{1'b0}};
      mask_r <= `ICC_MASK_RST;
    end else begin
      if (wr_en && paddr == `ICC_OFF_MASK) begin
        mask_r <= pwdata[`ICC_ST_W-1:0];
      end
      if (wr_en && paddr == `ICC_OFF_STAT) begin
        stat_r <= (stat_r & ~pwdata[`ICC_ST_W-1:0]) |
                  {ov_evt, int_evt};
      end else begin
        stat_r <= stat_r | {ov_evt, int_evt};
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // ****************************************
  // read path
  // ****************************************

  // read data is chosen in setup so it is stable in access
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ICC_OFF_CTRL: rd_mux[7:0] = ctrl_rd;
      `ICC_OFF_BUF: begin
        if (!empty) begin
          rd_mux[TW-1:0] = mem_r[rd_ptr_r];
        end
      end
      `ICC_OFF_STAT: rd_mux[`ICC_ST_W-1:0] = stat_r;
      `ICC_OFF_MASK: rd_mux[`ICC_ST_W-1:0] = mask_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // the pop is booked at setup, so a capture landing in between
  // cannot slip past the value handed out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pop_pend_r <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pop_pend_r <= ~pwrite & (paddr == `ICC_OFF_BUF) & ~empty;
    end else if (access) begin
      pop_pend_r <= 1'b0;
    end
  end

endmodule // icc_core

//--- core/icc_map.vh
`ifndef ICC_MAP_VH
`define ICC_MAP_VH

// register byte offsets
`define ICC_OFF_CTRL 8'h00
`define ICC_OFF_BUF 8'h04
`define ICC_OFF_STAT 8'h08
`define ICC_OFF_MASK 8'h0C

// control register fields
`define ICC_TMR_BIT 7
`define ICC_ICI_HI 6
`define ICC_ICI_LO 5
`define ICC_OV_BIT 4
`define ICC_BNE_BIT 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0

// status and mask fields
`define ICC_ST_CAP_BIT 0
`define ICC_ST_OV_BIT 1
`define ICC_ST_W 2

// reset values
`define ICC_CTRL_RST 8'h00
`define ICC_MASK_RST 2'b00

// capture mode codes
`define ICC_M_OFF 3'b000
`define ICC_M_BOTH 3'b001
`define ICC_M_FALL 3'b010
`define ICC_M_RISE 3'b011
`define ICC_M_DIV4 3'b100
`define ICC_M_DIV16 3'b101
`define ICC_M_UNUSED 3'b110
`define ICC_M_INTONLY 3'b111

// prescaler terminal counts
`define ICC_DIV4_LAST 4'h3
`define ICC_DIV16_LAST 4'hF

`endif

//--- tb/icc_core_props.sv
`timescale 1ns/1ps
`include "icc_map.vh"
module icc_chk (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // interrupt
  input wire irq
);
  // ****
  // apb and interrupt properties
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // address outside the four words
  wire bad = paddr != `ICC_OFF_CTRL && paddr != `ICC_OFF_BUF &&
    paddr != `ICC_OFF_STAT && paddr != `ICC_OFF_MASK;
  sequence s_acc; psel && penable; endsequence
  sequence s_rd; s_acc ##0 !pwrite; endsequence
  sequence s_mask0;
    s_acc ##0 pwrite && paddr == `ICC_OFF_MASK && pwdata[1:0] == 2'b00;
  endsequence
  AST_READY: assert property (pready) else $error("pready low");
  AST_ERR_BAD: assert property (s_acc ##0 bad |-> pslverr)
    else $error("no error on unmapped");
  AST_ERR_OK: assert property (s_acc ##0 !bad |-> !pslverr)
    else $error("error on mapped");
  AST_ERR_IDLE: assert property (!penable |-> !pslverr)
    else $error("error outside access");
  AST_RD_BAD: assert property (s_rd ##0 bad |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_CTRL: assert property (s_rd ##0 paddr == `ICC_OFF_CTRL |->
    prdata[31:8] == 24'h00_0000) else $error("control upper bits set");
  AST_RD_HOLD: assert property (s_rd ##1 !(psel && !penable) |->
    $stable(prdata)) else $error("read data moved");
  // a cleared mask must drop the line at once
  AST_MASK0: assert property (s_mask0 |=> (!irq) [*2])
    else $error("irq with mask clear");
endmodule // icc_chk

bind icc_core icc_chk u_icc_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .irq(irq));

//--- tb/icc_core_tb.sv
`timescale 1ns/1ps
module icc_core_tb;
  // ****
  // bench
  // ****
  reg pclk, presetn, psel, penable, pwrite, ev;
  reg [7:0] paddr;
  reg [31:0] pwdata, rv;
  wire pready, pslverr, irq, cap_pin;
  wire [31:0] prdata;
  wire [15:0] timer_a, timer_b;
  integer err_count, checks_done, cyc, i;
  localparam [7:0] a_ctl = 8'h00, a_buf = 8'h04, a_st = 8'h08;
  icc_core u_icc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cap_pin(cap_pin), .timer_a(timer_a), .timer_b(timer_b), .irq(irq));
  icc_tmr_model u_icc_tmr_model (.pclk(pclk), .cap_pin(cap_pin),
    .timer_a(timer_a), .timer_b(timer_b));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one idle edge first, so psel is never set twice in a step
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d); apb(1'b1, a, d); endtask
  task ck(input string nm, input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rv, e);
    end
  endtask
  task ci(input e);
    begin
      @(posedge pclk);
      chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, e});
    end
  endtask
  // drain, stop, clear status, restart in mode c, send n pulses
  task run(input [7:0] c, input integer n);
    begin
      repeat (4) apb(1'b0, a_buf, 32'h0000_0000);
      wr(a_ctl, 32'h0000_0000);
      wr(a_st, 32'h0000_0003);
      wr(a_ctl, {24'h00_0000, c});
      u_icc_tmr_model.pulses(n);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // hang guard, far above the roughly 800 cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {err_count, checks_done, cyc} = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    ck("ctl", a_ctl, 32'h0000_0000);
    chk("err", {31'h0000_0000, ev}, 32'h0000_0000);
    ck("bad", 8'h10, 32'h0000_0000);
    chk("err", {31'h0000_0000, ev}, 32'h0000_0001);
    u_icc_tmr_model.load(16'h1234, 16'hBEEF);
    run(8'h03, 1);
    ck("ctl", a_ctl, 32'h0000_000B);
    ck("buf", a_buf, 32'h0000_1234);
    ck("ctl", a_ctl, 32'h0000_0003);
    run(8'h82, 1);
    ck("buf", a_buf, 32'h0000_BEEF);
    // prescalers: one short of the count, then the count
    run(8'h04, 3);
    ck("buf", a_buf, 32'h0000_0000);
    u_icc_tmr_model.pulses(1);
    ck("buf", a_buf, 32'h0000_1234);
    run(8'h05, 15);
    ck("ctl", a_ctl, 32'h0000_0005);
    u_icc_tmr_model.pulses(1);
    ck("ctl", a_ctl, 32'h0000_000D);
    // both edges, field set to its largest code
    run(8'h61, 1);
    ck("st", a_st, 32'h0000_0001);
    repeat (2) ck("buf", a_buf, 32'h0000_1234);
    ck("buf", a_buf, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) begin
      run({1'b0, i[1:0], 5'h03}, i);
      ck("st", a_st, 32'h0000_0000);
      u_icc_tmr_model.pulses(1);
      ck("st", a_st, 32'h0000_0001);
    end
    run(8'hE7, 1);
    ck("st", a_st, 32'h0000_0001);
    ck("buf", a_buf, 32'h0000_0000);
    run(8'h06, 2);
    ck("st", a_st, 32'h0000_0000);
    ck("buf", a_buf, 32'h0000_0000);
    // overflow with interrupt masking and clearing
    wr(8'h0C, 32'h0000_0002);
    run(8'h03, 5);
    ck("ctl", a_ctl, 32'h0000_001B);
    ck("st", a_st, 32'h0000_0003);
    ci(1'b1);
    wr(a_st, 32'h0000_0002);
    ck("st", a_st, 32'h0000_0001);
    ci(1'b0);
    wr(8'h0C, 32'h0000_0001);
    ci(1'b1);
    wr(8'h0C, 32'h0000_0000);
    ci(1'b0);
    run(8'h00, 0);
    ck("ctl", a_ctl, 32'h0000_0000);
    finish_test;
  end
endmodule // icc_core_tb

//--- tb/icc_tmr_model.sv
`timescale 1ns/1ps
module icc_tmr_model (
  // clock
  input wire pclk,
  // pin and timer counts
  output reg cap_pin = 1'b0,
  output reg [15:0] timer_a = 16'h0000,
  output reg [15:0] timer_b = 16'h0000
);
  // ****
  // pin and timers
  // ****
  // timers move only while the pin idles, so captures are exact
  task load(input [15:0] a, input [15:0] b);
    begin
      @(posedge pclk);
      timer_a <= a;
      timer_b <= b;
    end
  endtask
  // long phases so each edge survives the two-flop sync
  task pulses(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge pclk);
        cap_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        cap_pin <= 1'b0;
        repeat (5) @(posedge pclk);
      end
    end
  endtask
endmodule // icc_tmr_model
